// ===== hdl/period_timer.sv
// battery-mode sensing period timer, one due pulse per period
`timescale 1ns/100ps
module period_timer #(
	parameter int unsigned SEC_COUNT = trim_pkg::SEC_CYCLES
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic run,
	input  wire logic short_sel,
	output logic      due
);
	import trim_pkg::*;

	typedef struct packed {
		logic [31:0] cyc;
		logic [9:0]  secs;
		logic        due;
	} tmr_t;

	tmr_t s_reg;
	tmr_t s_next;
	logic [9:0] target;

	// ==========================================================
	// counter
	always_comb begin
		s_next = s_reg;
		s_next.due = 1'b0;
		target = short_sel ? PERIOD_SHORT_SEC : PERIOD_LONG_SEC;
		if (!run) begin
			s_next.cyc = 32'h0;
			s_next.secs = 10'h000;
		end else if (s_reg.cyc == 32'(SEC_COUNT - 1)) begin
			s_next.cyc = 32'h0;
			if (s_reg.secs == target - 10'h001) begin
				s_next.secs = 10'h000;
				s_next.due = 1'b1;
			end else begin
				s_next.secs = s_reg.secs + 10'h001;
			end
		end else begin
			s_next.cyc = s_reg.cyc + 32'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign due = s_reg.due;

endmodule // period_timer

// ===== hdl/temp_comp_trim_regs.sv
// trim, curvature and compensation control registers with sensing sequencer
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/100ps
module temp_comp_trim_regs #(
	parameter int unsigned SEC_COUNT = trim_pkg::SEC_CYCLES
) (
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	input  wire logic [trim_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]                  s_axi_awprot,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [trim_pkg::DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [trim_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]                  s_axi_arprot,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [trim_pkg::DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	input  wire logic                        battery_mode,
	input  wire logic                        vbat_low,
	input  wire logic                        conv_done,
	input  wire logic [9:0]                  conv_data,
	input  wire logic signed [5:0]           analog_correction,
	output logic                             sensor_power,
	output logic                             conv_start,
	output logic [9:0]                       temp_result,
	output logic [5:0]                       osc_analog_trim,
	output logic [1:0]                       osc_digital_trim,
	output logic signed [6:0]                osc_trim_ppm,
	output logic signed [9:0]                osc_digital_tenths,
	output logic [6:0]                       curvature_used,
	output logic [4:0]                       step_gain_used
);
	import trim_pkg::*;

	typedef struct packed {
		logic              bm_s1;
		logic              bm_s2;
		logic              vl_s1;
		logic              vl_s2;
		logic              awready;
		logic              aw_hold;
		logic [7:0]        awaddr;
		logic              wready;
		logic              w_hold;
		logic [7:0]        wdata;
		logic              wlane0;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [1:0]        rresp;
		logic [9:0]        rdata;
		logic [7:0]        init_trim;
		logic [6:0]        cold_coef;
		logic              sense_en;
		logic              batt_en;
		logic              period_sel;
		logic [4:0]        gain;
		seq_t              seq;
		logic              conv_start;
		logic [9:0]        first;
		logic [9:0]        temp;
		logic [4:0]        gain_used;
		logic [6:0]        coef_used;
		logic [5:0]        fin_atrim;
		logic [1:0]        fin_dtrim;
		logic              fin_valid;
		logic [5:0]        osc_atrim;
		logic [1:0]        osc_dtrim;
		logic signed [6:0] osc_ppm;
		logic signed [9:0] osc_tenths;
		logic              sensor_power;
	} state_t;

	state_t s_reg;
	state_t s_next;

	logic              allowed;
	logic              allow_nx;
	logic              batt_run;
	logic              due;
	logic              start;
	logic              wr_go;
	logic [5:0]        comp_code;
	logic [5:0]        sel_atrim;
	logic [1:0]        sel_dtrim;
	logic signed [6:0] sel_ppm;
	logic signed [9:0] sel_tenths;
	logic [10:0]       pair_sum;

	// ==========================================================
	// helpers
	period_timer #(
		.SEC_COUNT (SEC_COUNT)
	) u_period (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.run       (batt_run),
		.short_sel (s_reg.period_sel),
		.due       (due)
	);

	trim_map u_comp_map (
		.base_code  (s_reg.init_trim[ATRIM_MSB:0]),
		.corr       (analog_correction),
		.dig_code   (s_reg.init_trim[7:DTRIM_LSB]),
		.sum_code   (comp_code),
		.ppm        (),
		.dig_tenths ()
	);

	trim_map u_osc_map (
		.base_code  (sel_atrim),
		.corr       (6'sh00),
		.dig_code   (sel_dtrim),
		.sum_code   (),
		.ppm        (sel_ppm),
		.dig_tenths (sel_tenths)
	);

	// ==========================================================
	// sensing permission
	always_comb begin
		// low battery overrides the enable bit, not the other way round
		allowed = s_reg.sense_en & (~s_reg.bm_s2 | (s_reg.batt_en & ~s_reg.vl_s2));
		batt_run = s_reg.bm_s2 & allowed;
		wr_go = s_reg.aw_hold & s_reg.w_hold & ~s_reg.bvalid;
		pair_sum = {1'b0, s_reg.first} + {1'b0, conv_data};
		if (allowed & s_reg.fin_valid) begin
			sel_atrim = s_reg.fin_atrim;
			sel_dtrim = s_reg.fin_dtrim;
		end else begin
			sel_atrim = s_reg.init_trim[ATRIM_MSB:0];
			sel_dtrim = s_reg.init_trim[7:DTRIM_LSB];
		end
	end

	// ==========================================================
	// next state
	always_comb begin
		s_next = s_reg;
		start = 1'b0;
		s_next.bm_s1 = battery_mode;
		s_next.bm_s2 = s_reg.bm_s1;
		s_next.vl_s1 = vbat_low;
		s_next.vl_s2 = s_reg.vl_s1;
		s_next.conv_start = 1'b0;

		// write channels, taken in either order
		if (s_axi_awvalid && s_reg.awready) begin
			s_next.aw_hold = 1'b1;
			s_next.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_reg.wready) begin
			s_next.w_hold = 1'b1;
			s_next.wdata = s_axi_wdata[7:0];
			s_next.wlane0 = s_axi_wstrb[0];
		end
		if (s_reg.bvalid && s_axi_bready) begin
			s_next.bvalid = 1'b0;
		end
		if (wr_go) begin
			s_next.aw_hold = 1'b0;
			s_next.w_hold = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = RESP_OKAY;
			case (s_reg.awaddr)
				ADDR_INIT_TRIM: begin
					if (s_reg.wlane0) begin
						s_next.init_trim = s_reg.wdata;
					end
				end
				ADDR_COLD_COEF: begin
					if (s_reg.wlane0) begin
						s_next.cold_coef = s_reg.wdata[COEF_MSB:0];
					end
				end
				ADDR_CTRL: begin
					if (s_reg.wlane0) begin
						s_next.sense_en = s_reg.wdata[SENSE_BIT];
						s_next.batt_en = s_reg.wdata[BATT_BIT];
						s_next.period_sel = s_reg.wdata[PERIOD_BIT];
						s_next.gain = s_reg.wdata[GAIN_MSB:0];
						start = s_reg.wdata[SENSE_BIT] & ~s_reg.sense_en;
					end
				end
				ADDR_TEMP, ADDR_STATUS: begin
					s_next.bresp = RESP_OKAY;
				end
				default: begin
					s_next.bresp = RESP_SLVERR;
				end
			endcase
		end
		s_next.awready = ~s_next.aw_hold & ~s_next.bvalid;
		s_next.wready = ~s_next.w_hold & ~s_next.bvalid;
		// permission after this edge, so the enabling write itself starts a cycle
		allow_nx = s_next.sense_en & (~s_reg.bm_s2 | (s_next.batt_en & ~s_reg.vl_s2));

		// read channel, one outstanding read
		if (s_reg.rvalid && s_axi_rready) begin
			s_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_reg.arready) begin
			s_next.rvalid = 1'b1;
			s_next.rresp = RESP_OKAY;
			s_next.rdata = 10'h000;
			case (s_axi_araddr)
				ADDR_INIT_TRIM: s_next.rdata = {2'h0, s_reg.init_trim};
				ADDR_COLD_COEF: s_next.rdata = {3'h0, s_reg.cold_coef};
				ADDR_CTRL: begin
					s_next.rdata = {2'h0, s_reg.sense_en, s_reg.batt_en,
						s_reg.period_sel, s_reg.gain};
				end
				ADDR_TEMP: s_next.rdata = s_reg.temp;
				ADDR_STATUS: begin
					s_next.rdata[ST_BUSY] = (s_reg.seq != S_IDLE);
					s_next.rdata[ST_COMP] = allowed & s_reg.fin_valid;
					s_next.rdata[ST_BATT] = s_reg.bm_s2;
					s_next.rdata[ST_VLOW] = s_reg.vl_s2;
				end
				default: s_next.rresp = RESP_SLVERR;
			endcase
		end
		s_next.arready = ~s_next.rvalid;

		// ==========================================================
		// sensing sequencer
		if (due) begin
			start = 1'b1;
		end
		case (s_reg.seq)
			S_IDLE: begin
				if (start && allow_nx) begin
					// step gain and coefficient are sampled here, so a gain
					// rewritten with sensing on is used by the next cycle
					s_next.gain_used = s_next.gain;
					s_next.coef_used = s_reg.cold_coef;
					s_next.conv_start = 1'b1;
					s_next.seq = S_CONV1;
				end
			end
			S_CONV1: begin
				if (conv_done) begin
					s_next.first = conv_data;
					s_next.conv_start = 1'b1;
					s_next.seq = S_CONV2;
				end
			end
			S_CONV2: begin
				if (conv_done) begin
					s_next.temp = pair_sum[10:1];
					s_next.fin_atrim = comp_code;
					s_next.fin_dtrim = s_reg.init_trim[7:DTRIM_LSB];
					s_next.fin_valid = 1'b1;
					s_next.seq = S_IDLE;
				end
			end
			default: begin
				s_next.seq = S_IDLE;
			end
		endcase
		// losing permission aborts the cycle and drops final trims
		if (!allow_nx) begin
			s_next.seq = S_IDLE;
			s_next.conv_start = 1'b0;
			s_next.fin_valid = 1'b0;
		end
		s_next.sensor_power = allow_nx;

		// ==========================================================
		// oscillator drive, registered
		s_next.osc_atrim = sel_atrim;
		s_next.osc_dtrim = sel_dtrim;
		s_next.osc_ppm = sel_ppm;
		s_next.osc_tenths = sel_tenths;
	end

	// ==========================================================
	// state register; reset doubles as the power-up preset recall
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '0;
			s_reg.init_trim <= PRESET_INIT_TRIM;
			s_reg.cold_coef <= PRESET_COLD_COEF;
			s_reg.gain <= PRESET_GAIN;
			s_reg.gain_used <= PRESET_GAIN;
			s_reg.coef_used <= PRESET_COLD_COEF;
			s_reg.sense_en <= 1'b0;
			s_reg.batt_en <= 1'b0;
			s_reg.seq <= S_IDLE;
			s_reg.osc_atrim <= PRESET_INIT_TRIM[ATRIM_MSB:0];
			s_reg.osc_dtrim <= PRESET_INIT_TRIM[7:DTRIM_LSB];
		end else begin
			s_reg <= s_next;
		end
	end

	// ==========================================================
	// outputs
	assign s_axi_awready      = s_reg.awready;
	assign s_axi_wready       = s_reg.wready;
	assign s_axi_bvalid       = s_reg.bvalid;
	assign s_axi_bresp        = s_reg.bresp;
	assign s_axi_arready      = s_reg.arready;
	assign s_axi_rvalid       = s_reg.rvalid;
	assign s_axi_rresp        = s_reg.rresp;
	assign s_axi_rdata        = {22'h0, s_reg.rdata};
	assign sensor_power       = s_reg.sensor_power;
	assign conv_start         = s_reg.conv_start;
	assign temp_result        = s_reg.temp;
	assign osc_analog_trim    = s_reg.osc_atrim;
	assign osc_digital_trim   = s_reg.osc_dtrim;
	assign osc_trim_ppm       = s_reg.osc_ppm;
	assign osc_digital_tenths = s_reg.osc_tenths;
	assign curvature_used     = s_reg.coef_used;
	assign step_gain_used     = s_reg.gain_used;

endmodule // temp_comp_trim_regs

// ===== hdl/trim_map.sv
// analog trim saturating adjust and code to ppm mapping
`timescale 1ns/100ps
module trim_map (
	input  wire logic [5:0]        base_code,
	input  wire logic signed [5:0] corr,
	input  wire logic [1:0]        dig_code,
	output logic [5:0]             sum_code,
	output logic signed [6:0]      ppm,
	output logic signed [9:0]      dig_tenths
);
	import trim_pkg::*;

	logic signed [7:0] sum;

	// ==========================================================
	// saturate so a large correction cannot wrap across the span
	always_comb begin
		sum = $signed({2'h0, base_code}) + 8'(corr);
		if (sum < 0) begin
			sum_code = 6'h00;
		end else if (sum > 8'sd63) begin
			sum_code = 6'h3F;
		end else begin
			sum_code = sum[5:0];
		end
		ppm = $signed(ATRIM_TOP_PPM) - $signed({1'b0, sum_code});
		case (dig_code)
			DT_PLUS:  dig_tenths = DT_STEP_TENTHS;
			DT_MINUS: dig_tenths = -DT_STEP_TENTHS;
			default:  dig_tenths = 10'sh000;
		endcase
	end

endmodule // trim_map

// ===== hdl/trim_pkg.sv
// constants and types for the trim and compensation register bank
// ==========================================================
// Contract
// - six-bit analog trim moves frequency one ppm per code, +32 to -31 ppm
// - analog code 0 is +32 ppm, 32 is zero, 63 is -31 ppm, linear
// - reset recalls factory trim and curvature presets; software may overwrite them
// - trim byte: digital trim in bits 7:6, analog trim in bits 5:0
// - coefficient byte holds cold curvature coefficient in bits 6:0
// - control byte: sense enable 7, battery enable 6, period 5, gain 4:0
// - sense enable gates sensor, converter and final trim updates; resets to 0
// - with sensing off the oscillator runs from the initial trims
// - writing sense enable 1 runs two conversions and stores their average; here only a write that sets the bit from 0 starts them
// - battery sensing enable allows sensing on battery; off by default
// - battery below 2.7 V disables battery sensing regardless of the bit
// - on battery, sense every ten minutes or every minute by period select
// - digital trim: 00 default, 01 +30.5, 10 zero, 11 -30.5 ppm
package trim_pkg;

	// ==========================================================
	// bus
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// ==========================================================
	// register indices, byte address is four times the index
	localparam logic [5:0] IDX_INIT_TRIM  = 6'h0B;
	localparam logic [5:0] IDX_COLD_COEF  = 6'h0C;
	localparam logic [5:0] IDX_CTRL       = 6'h0D;
	localparam logic [5:0] IDX_TEMP       = 6'h28;
	localparam logic [5:0] IDX_STATUS     = 6'h29;
	localparam logic [7:0] ADDR_INIT_TRIM = {IDX_INIT_TRIM, 2'h0};
	localparam logic [7:0] ADDR_COLD_COEF = {IDX_COLD_COEF, 2'h0};
	localparam logic [7:0] ADDR_CTRL      = {IDX_CTRL, 2'h0};
	localparam logic [7:0] ADDR_TEMP      = {IDX_TEMP, 2'h0};
	localparam logic [7:0] ADDR_STATUS    = {IDX_STATUS, 2'h0};

	// ==========================================================
	// field positions
	localparam int unsigned DTRIM_LSB  = 6;
	localparam int unsigned ATRIM_MSB  = 5;
	localparam int unsigned COEF_MSB   = 6;
	localparam int unsigned SENSE_BIT  = 7;
	localparam int unsigned BATT_BIT   = 6;
	localparam int unsigned PERIOD_BIT = 5;
	localparam int unsigned GAIN_MSB   = 4;
	localparam int unsigned ST_BUSY    = 0;
	localparam int unsigned ST_COMP    = 1;
	localparam int unsigned ST_BATT    = 2;
	localparam int unsigned ST_VLOW    = 3;

	// ==========================================================
	// factory presets (plain defaults) and trim coding
	localparam logic [7:0] PRESET_INIT_TRIM = 8'hA0;
	localparam logic [6:0] PRESET_COLD_COEF = 7'h46;
	localparam logic [4:0] PRESET_GAIN      = 5'h00;
	localparam logic [6:0] ATRIM_TOP_PPM    = 7'h20;
	localparam logic [1:0] DT_PLUS          = 2'h1;
	localparam logic [1:0] DT_MINUS         = 2'h3;
	localparam logic signed [9:0] DT_STEP_TENTHS = 10'sd305;

	// ==========================================================
	// timing
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned SECOND_NS     = 1000000000;
	localparam int unsigned SEC_CYCLES    = SECOND_NS / CLK_PERIOD_NS;
	localparam int unsigned SEC_PER_MIN   = 60;
	localparam int unsigned PERIOD_LONG_MIN  = 10;
	localparam int unsigned PERIOD_SHORT_MIN = 1;
	localparam logic [9:0] PERIOD_LONG_SEC  = 10'(PERIOD_LONG_MIN * SEC_PER_MIN);
	localparam logic [9:0] PERIOD_SHORT_SEC = 10'(PERIOD_SHORT_MIN * SEC_PER_MIN);

	typedef enum logic [1:0] {S_IDLE, S_CONV1, S_CONV2} seq_t;

endpackage

// ===== verification/temp_comp_trim_regs_assertions.sv
// concurrent checks on the ports of the trim register bank
`timescale 1ns/100ps
module temp_comp_trim_regs_checker #(
	parameter int unsigned SEC_COUNT = trim_pkg::SEC_CYCLES
) (
	input wire logic               aclk,
	input wire logic               aresetn,
	input wire logic               s_axi_awvalid,
	input wire logic               s_axi_awready,
	input wire logic               s_axi_wvalid,
	input wire logic               s_axi_wready,
	input wire logic               s_axi_bvalid,
	input wire logic [7:0]         s_axi_araddr,
	input wire logic               s_axi_arvalid,
	input wire logic               s_axi_arready,
	input wire logic [31:0]        s_axi_rdata,
	input wire logic               s_axi_rvalid,
	input wire logic               battery_mode,
	input wire logic               vbat_low,
	input wire logic               conv_done,
	input wire logic [9:0]         conv_data,
	input wire logic               sensor_power,
	input wire logic               conv_start,
	input wire logic [9:0]         temp_result,
	input wire logic [5:0]         osc_analog_trim,
	input wire logic [1:0]         osc_digital_trim,
	input wire logic signed [6:0]  osc_trim_ppm,
	input wire logic signed [9:0]  osc_digital_tenths
);
	import trim_pkg::*;

	// ==========================================================
	// last two conversion results, for the average
	logic [9:0] d0_reg, d1_reg;
	always_ff @(posedge aclk) begin
		if (conv_done) begin
			d0_reg <= conv_data;
			d1_reg <= d0_reg;
		end
	end

	// ==========================================================
	// properties
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	write_resp_timing_a: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response timing");
	coef_bit_zero_a: assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_COLD_COEF
		|=> s_axi_rvalid && !s_axi_rdata[7])
		else $error("coefficient bit 7 set");
	analog_ppm_map_a: assert property (
		osc_trim_ppm == 7'h20 - {1'b0, osc_analog_trim})
		else $error("analog ppm mapping");
	digital_tenths_map_a: assert property (
		osc_digital_tenths == ((osc_digital_trim == DT_PLUS) ? DT_STEP_TENTHS
		: (osc_digital_trim == DT_MINUS) ? -DT_STEP_TENTHS : 10'sh000))
		else $error("digital tenths mapping");
	reset_sense_off_a: assert property ($rose(aresetn) |-> !sensor_power && !conv_start)
		else $error("sensing on after reset");
	start_needs_power_a: assert property (conv_start |-> sensor_power)
		else $error("conversion without sensing");
	start_single_a: assert property (conv_start |=> !conv_start)
		else $error("conversion start too long");
	conv_average_a: assert property (
		conv_done && sensor_power ##1 !conv_start && sensor_power
		|-> temp_result == 10'((11'(d0_reg) + 11'(d1_reg)) >> 1))
		else $error("temperature average");
	// five cycles cover the two-flop synchroniser and the output register
	vbat_low_off_a: assert property ((battery_mode && vbat_low) [*5] |-> !sensor_power)
		else $error("sensing on low battery");

	cover property (conv_done ##1 !conv_start);
	cover property ($fell(sensor_power));
	cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_COLD_COEF);
endmodule // temp_comp_trim_regs_checker

bind temp_comp_trim_regs temp_comp_trim_regs_checker #(.SEC_COUNT(SEC_COUNT)) u_checker (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .battery_mode, .vbat_low, .conv_done, .conv_data, .sensor_power,
	.conv_start, .temp_result, .osc_analog_trim, .osc_digital_trim, .osc_trim_ppm,
	.osc_digital_tenths
);

// ===== verification/temp_comp_trim_regs_tb_top.sv
// self-checking bench for the trim register bank
`timescale 1ns/100ps
module temp_comp_trim_regs_tb_top;
	import trim_pkg::*;

	// ==========================================================
	// signals
	localparam int unsigned SEC_SIM = 10;
	logic              aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0;
	logic              s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic              s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	logic              battery_mode = 1'b0, vbat_low = 1'b0, conv_done = 1'b0;
	logic [7:0]        s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0]       s_axi_wdata = 32'h00000000, s_axi_rdata;
	logic [3:0]        s_axi_wstrb = 4'hF;
	logic [2:0]        s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, dly = 3'h0;
	logic [9:0]        conv_data = 10'h000, cval = 10'h000, base, temp_result;
	logic signed [5:0] analog_correction = 6'sh00;
	logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic              s_axi_rvalid, sensor_power, conv_start;
	logic [1:0]        s_axi_bresp, s_axi_rresp, osc_digital_trim, resp;
	logic [5:0]        osc_analog_trim;
	logic signed [6:0] osc_trim_ppm, ep;
	logic signed [9:0] osc_digital_tenths, et;
	logic [6:0]        curvature_used;
	logic [4:0]        step_gain_used;
	// code 63 left out, the highest codes upset oscillator start-up
	logic [7:0]        tv [4] = '{8'h00, 8'h60, 8'hA1, 8'hFE};
	int                error_cnt = 0, check_count = 0, cyc = 0, n;

	always #5 aclk = ~aclk;

	temp_comp_trim_regs #(.SEC_COUNT(SEC_SIM)) u_dut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.battery_mode, .vbat_low, .conv_done, .conv_data, .analog_correction,
		.sensor_power, .conv_start, .temp_result, .osc_analog_trim, .osc_digital_trim,
		.osc_trim_ppm, .osc_digital_tenths, .curvature_used, .step_gain_used
	);

	// ==========================================================
	// converter stand-in: done four cycles after each start
	always @(posedge aclk) begin
		conv_done <= (dly == 3'h1);
		dly <= conv_start ? 3'h3 : (dly != 3'h0) ? dly - 3'h1 : 3'h0;
		if (dly == 3'h1) begin
			conv_data <= cval;
			cval <= cval + 10'h006;
		end
	end

	// ==========================================================
	// tasks
	task automatic end_sim();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
		logic ap, wp;
		ap = 1'b1;
		wp = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (ap || wp) begin
			@(posedge aclk);
			ap = ap && !s_axi_awready;
			wp = wp && !s_axi_wready;
			s_axi_awvalid <= ap;
			s_axi_wvalid <= wp;
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		resp = s_axi_bresp;
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		chk(nm, e, s_axi_rdata);
		chk(nm, er, s_axi_rresp);
	endtask

	task automatic wait_start(input int lim);
		n = 0;
		while (!conv_start && n < lim) begin
			@(posedge aclk);
			n++;
		end
	endtask

	// ==========================================================
	// hang guard, longest path is three ten-minute periods
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			error_cnt++;
			end_sim();
		end
	end

	// ==========================================================
	// sequence
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd_chk("trim", ADDR_INIT_TRIM, {24'h0, PRESET_INIT_TRIM}, RESP_OKAY);
		rd_chk("coef", ADDR_COLD_COEF, {25'h0, PRESET_COLD_COEF}, RESP_OKAY);
		rd_chk("ctrl", ADDR_CTRL, 32'h00000000, RESP_OKAY);
		rd_chk("unmapped", 8'h00, 32'h00000000, RESP_SLVERR);
		wr(8'h00, 8'h55, 4'hF);
		chk("unmapped wr", RESP_SLVERR, resp);
		foreach (tv[i]) begin
			wr(ADDR_INIT_TRIM, tv[i], 4'hF);
			repeat (4) @(posedge aclk);
			ep = 7'sh20 - $signed({1'b0, tv[i][5:0]});
			et = (tv[i][7:6] == DT_PLUS) ? DT_STEP_TENTHS : 10'sh000;
			if (tv[i][7:6] == DT_MINUS)
				et = -DT_STEP_TENTHS;
			chk("analog", tv[i][5:0], osc_analog_trim);
			chk("digital", tv[i][7:6], osc_digital_trim);
			chk("ppm", ep, osc_trim_ppm);
			chk("tenths", et, osc_digital_tenths);
			rd_chk("trim rb", ADDR_INIT_TRIM, tv[i], RESP_OKAY);
		end
		wr(ADDR_INIT_TRIM, 8'h00, 4'h0);
		rd_chk("strobe", ADDR_INIT_TRIM, tv[3], RESP_OKAY);
		wr(ADDR_INIT_TRIM, 8'hA0, 4'hF);
		wr(ADDR_COLD_COEF, 8'hFF, 4'hF);
		rd_chk("coef rb", ADDR_COLD_COEF, 32'h0000007F, RESP_OKAY);
		// 0.034 times 2048 rounds to 70
		wr(ADDR_COLD_COEF, 8'h46, 4'hF);
		analog_correction <= 6'sh03;
		wr(ADDR_CTRL, 8'h13, 4'hF);
		rd_chk("ctrl rb", ADDR_CTRL, 32'h00000013, RESP_OKAY);
		chk("sense off", 1'b0, sensor_power);
		base = cval;
		wr(ADDR_CTRL, 8'h93, 4'hF);
		for (n = 0; n < 100 && temp_result !== base + 10'h003; n++) @(posedge aclk);
		chk("temp", base + 10'h003, temp_result);
		chk("gain", 5'h13, step_gain_used);
		chk("curv", 7'h46, curvature_used);
		repeat (2) @(posedge aclk);
		chk("final", 6'h23, osc_analog_trim);
		rd_chk("temp rb", ADDR_TEMP, {22'h0, 10'(base + 10'h003)}, RESP_OKAY);
		wr(ADDR_CTRL, 8'h13, 4'hF);
		repeat (3) @(posedge aclk);
		chk("revert", 6'h20, osc_analog_trim);
		chk("power off", 1'b0, sensor_power);
		battery_mode <= 1'b1;
		repeat (4) @(posedge aclk);
		wr(ADDR_CTRL, 8'h93, 4'hF);
		repeat (8) @(posedge aclk);
		chk("batt off", 1'b0, sensor_power);
		for (int p = 0; p < 2; p++) begin
			wr(ADDR_CTRL, {2'b11, 1'(p), 5'h13}, 4'hF);
			repeat (2) begin
				wait_start(8000);
				repeat (10) @(posedge aclk);
			end
			wait_start(8000);
			chk("period", (p ? PERIOD_SHORT_SEC : PERIOD_LONG_SEC) * SEC_SIM - 10, n);
		end
		chk("batt comp", 6'h23, osc_analog_trim);
		vbat_low <= 1'b1;
		repeat (8) @(posedge aclk);
		chk("vbat low", 1'b0, sensor_power);
		chk("no comp", 6'h20, osc_analog_trim);
		rd_chk("status", ADDR_STATUS, 32'((1 << ST_BATT) | (1 << ST_VLOW)), RESP_OKAY);
		end_sim();
	end
endmodule // temp_comp_trim_regs_tb_top
